// [design/mbs_pkg.sv]
// Package: constants for the serial float/status request interpreter
package mbs_pkg;
   // Function codes
   localparam logic [7:0] FN_RD_BITS = 8'h01;
   localparam logic [7:0] FN_RD_INPS = 8'h02;
   localparam logic [7:0] FN_RD_HOLD = 8'h03;
   localparam logic [7:0] FN_RD_INPR = 8'h04;
   localparam logic [7:0] FN_WR_BIT = 8'h05;
   localparam logic [7:0] FN_WR_BITS = 8'h0f;
   localparam logic [7:0] FN_WR_REGS = 8'h10;
   localparam logic [7:0] FN_RD_F32 = 8'h41;
   localparam logic [7:0] FN_WR_F32 = 8'h42;
   // Exception codes
   localparam logic [7:0] EX_FUNC = 8'h01;
   localparam logic [7:0] EX_ADDR = 8'h02;
   localparam logic [7:0] EX_VALUE = 8'h03;
   localparam logic [7:0] EX_BUSY = 8'h04;
   // Register map (16-bit register numbers)
   localparam logic [15:0] INT_LEVEL = 16'h0000;
   localparam logic [15:0] INT_TEMP = 16'h0001;
   localparam logic [15:0] INT_LAST = 16'h0017;
   localparam logic [15:0] F32_TEMP = 16'h0001;
   localparam logic [15:0] F32_ADV_HI_TEMP = 16'h000c;
   localparam logic [15:0] F32_RSV_LO = 16'h0002;
   localparam logic [15:0] F32_LAST = 16'h001f;
   localparam logic [15:0] FPAIR_TEMP = 16'h0066;
   localparam logic [15:0] FPAIR_RSV = 16'h0068;
   localparam logic [15:0] FPAIR_ADV_HI = 16'h006e;
   localparam logic [15:0] FPAIR_LAST = 16'h006f;
   localparam logic [15:0] INT_PACKED = 16'h0005;
   localparam int NUM_BITS = 32;
   localparam logic [15:0] MAXINT_RST = 16'hfffe;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam int FRAME_MAX = 16;
   localparam logic [7:0] RESP_MAX = 8'd40;
   // Power-up busy window: 1 ms
   localparam int BUSY_US = 1000;
   localparam int CLK_MHZ = 10;
   localparam int BUSY_CYC = BUSY_US * CLK_MHZ;
endpackage : mbs_pkg

// [design/mbs_slave.sv]
// Design: serial slave request interpreter, float regs and status bits
// Function
// R1: Float pair read answers functions 03 and 04
// R2: Float pair write accepted with function 16
// R3: IEEE single, MSB first, upper half low
// R4: Reserved float registers always read zero
// R5: Writes to reserved float registers are discarded
// R6: Function 65 reads 32-bit float registers
// R7: Function 66 stores 32-bit float values
// R8: Status bits one is ON, functions 1/2
// R9: Functions 5 and 15 write status bits
// R10: Bit replies pack first bit at position zero
// R11: Bad function 01, busy 04 during power-up
// R12: Address outside map returns exception 02
// R13: Out-of-range written value returns exception 03
// R14: Parity, checksum or format faults dropped silently
// R15: Invalid scaled integer reads max integer plus one
// R16: Sentinel never used for bits or codes
// R17: Fault flags force sentinel on scaled reads
// R18: Maximum integer configurable from 0 to 65535
// R19: Frames end with CRC-16, low byte first
// R20: Function 66 reply echoes register count
`timescale 1ns/10ps
module mbs_slave #(
   parameter int BUSY_CYCLES = mbs_pkg::BUSY_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Configuration
   input wire logic [7:0] slave_addr_i,
   input wire logic [15:0] max_int_i, // see R18
   // Measured values
   input wire logic [31:0] temp_float_i,
   input wire logic [15:0] level_int_i,
   input wire logic [15:0] temp_int_i,
   input wire logic level_bad_i,
   input wire logic temp_bad_i,
   // Error conditions
   input wire logic offline_i,
   input wire logic strap_fault_i,
   input wire logic computation_absent_i,
   input wire logic correction_table_fault_i,
   input wire logic computation_fault_i,
   // Receive byte stream
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_eof_i,
   // Transmit byte stream
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o,
   // State
   output logic [mbs_pkg::NUM_BITS-1:0] status_bits_o,
   output logic [31:0] adv_hi_temp_o,
   output logic busy_o
);
   import mbs_pkg::*;
   if (BUSY_CYCLES < 1) begin : g_busy_chk
      $error("BUSY_CYCLES must be positive");
   end

   typedef enum logic [1:0] {
      ST_RX = 2'b00, ST_EXEC = 2'b01, ST_TX = 2'b11, ST_IDLE = 2'b10
   } st_e;

   typedef struct packed {
      st_e st;
      logic [FRAME_MAX-1:0][7:0] fr;
      logic [4:0] nrx;
      logic bad;
      logic [15:0] crc;
      logic [RESP_MAX-1:0][7:0] rs;
      logic [7:0] nrs;
      logic [7:0] txi;
      logic [15:0] tcrc;
      logic [1:0] tcp;
      logic [NUM_BITS-1:0] bits;
      logic [31:0] adv;
      logic [31:0] busy_cnt;
      logic busy;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_last;
   } state_s;

   state_s q, d;
   logic rst_m_q, rst_n_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   // Read of one 16-bit register from the pair/integer map
   function automatic logic [15:0] reg16(logic [15:0] a, logic sent,
                                         logic [31:0] adv);
      logic [15:0] top;
      top = max_int_i + 16'h0001; // see R15
      case (a)
         INT_LEVEL: return (sent | level_bad_i | level_int_i > max_int_i)
                           ? top : level_int_i; // see R17
         INT_TEMP: return (sent | temp_bad_i | temp_int_i > max_int_i)
                          ? top : temp_int_i; // see R17
         INT_PACKED: return q.bits[15:0]; // see R16
         FPAIR_TEMP: return temp_float_i[31:16]; // see R3
         FPAIR_TEMP + 16'h0001: return temp_float_i[15:0];
         FPAIR_ADV_HI: return adv[31:16];
         FPAIR_LAST: return adv[15:0];
         default: return 16'h0000; // see R4
      endcase
   endfunction : reg16

   function automatic logic ok16(logic [15:0] a);
      return (a <= INT_LAST) || (a >= FPAIR_TEMP && a <= FPAIR_LAST);
   endfunction : ok16

   logic [7:0] fn;
   logic [15:0] sa, cnt;
   logic sent;
   logic [31:0] f32;
   logic [7:0] ex;
   logic [7:0] n;

   always_comb begin
      d = q;
      fn = q.fr[1];
      sa = {q.fr[2], q.fr[3]};
      cnt = {q.fr[4], q.fr[5]};
      sent = offline_i | strap_fault_i | computation_absent_i
             | correction_table_fault_i | computation_fault_i; // see R17
      ex = 8'h00;
      n = 8'h00;
      f32 = 32'h0;
      d.tx_valid = 1'b0;
      d.tx_last = 1'b0;
      if (q.busy_cnt != 32'd0) d.busy_cnt = q.busy_cnt - 32'd1;
      d.busy = (q.busy_cnt > 32'd1);
      case (q.st)
         ST_RX: begin
            if (rx_valid_i) begin
               if (q.nrx < 5'(FRAME_MAX)) begin
                  d.fr[q.nrx[3:0]] = rx_data_i;
                  d.nrx = q.nrx + 5'd1;
               end else d.bad = 1'b1;
               d.crc = crc_step(q.crc, rx_data_i); // see R19
               if (rx_parity_err_i) d.bad = 1'b1; // see R14
            end
            if (rx_eof_i) begin
               // A good frame leaves a zero residue over data plus CRC
               if (!q.bad && q.nrx >= 5'd4 && q.crc == 16'h0000
                   && q.fr[0] == slave_addr_i) d.st = ST_EXEC; // see R14
               d.nrx = 5'd0;
               d.bad = 1'b0;
               d.crc = CRC_INIT;
            end
         end
         ST_EXEC: begin
            d.rs[0] = q.fr[0];
            d.rs[1] = fn;
            if (q.busy) begin
               ex = EX_BUSY; // see R11
            end else begin
               case (fn)
                  FN_RD_BITS, FN_RD_INPS: begin
                     if (cnt == 16'h0 || 32'(sa) + 32'(cnt) > NUM_BITS) begin
                        ex = EX_ADDR; // see R12
                     end else begin
                        n = 8'((cnt + 16'd7) >> 3);
                        d.rs[2] = n; // see R10
                        for (int i = 3; i < 7; i++) d.rs[i] = 8'h00;
                        for (int k = 0; k < NUM_BITS; k++) begin
                           if (k < 32'(cnt)) d.rs[3 + k / 8][k % 8] =
                              q.bits[5'(32'(sa) + k)]; // see R8
                        end
                        n = n + 8'd3;
                     end
                  end
                  FN_RD_HOLD, FN_RD_INPR: begin
                     if (cnt == 16'h0 || cnt > 16'd16 || !ok16(sa)
                         || !ok16(sa + cnt - 16'd1)) begin
                        ex = EX_ADDR;
                     end else begin
                        d.rs[2] = 8'(cnt << 1);
                        for (int i = 0; i < 16; i++) begin
                           if (i < 32'(cnt)) begin
                              {d.rs[3 + 2 * i], d.rs[4 + 2 * i]} =
                                 reg16(sa + 16'(i), sent, q.adv); // see R1
                           end
                        end
                        n = 8'(cnt << 1) + 8'd3;
                     end
                  end
                  FN_WR_BIT: begin
                     if (sa >= 16'(NUM_BITS)) begin
                        ex = EX_ADDR;
                     end else if (cnt != 16'hff00 && cnt != 16'h0000) begin
                        ex = EX_VALUE; // see R13
                     end else begin
                        d.bits[sa[4:0]] = cnt[15]; // see R9
                        for (int i = 2; i < 6; i++) d.rs[i] = q.fr[i];
                        n = 8'd6;
                     end
                  end
                  FN_WR_BITS: begin
                     if (cnt == 16'h0 || cnt > 16'd32
                         || 32'(sa) + 32'(cnt) > NUM_BITS) begin
                        ex = EX_ADDR;
                     end else begin
                        for (int k = 0; k < NUM_BITS; k++) begin
                           if (k < 32'(cnt)) d.bits[5'(32'(sa) + k)] =
                              q.fr[7 + k / 8][k % 8]; // see R9
                        end
                        for (int i = 2; i < 6; i++) d.rs[i] = q.fr[i];
                        n = 8'd6;
                     end
                  end
                  FN_WR_REGS: begin
                     if (cnt != 16'd2 || !ok16(sa)) begin
                        ex = EX_ADDR;
                     end else begin
                        if (sa == FPAIR_ADV_HI) begin
                           d.adv = {q.fr[7], q.fr[8], q.fr[9], q.fr[10]};
                        end // see R2
                        // Other targets, reserved among them, are left alone
                        for (int i = 2; i < 6; i++) d.rs[i] = q.fr[i];
                        n = 8'd6; // see R5
                     end
                  end
                  FN_RD_F32: begin
                     if (cnt == 16'h0 || cnt > 16'd8
                         || sa + cnt - 16'd1 > F32_LAST) begin
                        ex = EX_ADDR;
                     end else begin
                        d.rs[2] = q.fr[4];
                        d.rs[3] = q.fr[5]; // see R6
                        for (int i = 0; i < 8; i++) begin
                           if (i < 32'(cnt)) begin
                              f32 = 32'h0; // see R4
                              if (sa + 16'(i) == F32_TEMP) f32 = temp_float_i;
                              if (sa + 16'(i) == F32_ADV_HI_TEMP) f32 = q.adv;
                              {d.rs[4 + 4 * i], d.rs[5 + 4 * i],
                               d.rs[6 + 4 * i], d.rs[7 + 4 * i]} = f32;
                           end
                        end
                        n = 8'(cnt << 2) + 8'd4;
                     end
                  end
                  FN_WR_F32: begin
                     if (cnt != 16'd1 || sa > F32_LAST) begin
                        ex = EX_ADDR;
                     end else begin
                        if (sa == F32_ADV_HI_TEMP) begin
                           d.adv = {q.fr[6], q.fr[7], q.fr[8], q.fr[9]};
                        end // see R7
                        d.rs[2] = q.fr[4];
                        d.rs[3] = q.fr[5];
                        n = 8'd4; // see R20
                     end
                  end
                  default: ex = EX_FUNC; // see R11
               endcase
            end
            if (ex != 8'h00) begin
               d.rs[1] = fn | 8'h80;
               d.rs[2] = ex;
               n = 8'd3;
            end
            d.nrs = n;
            d.txi = 8'd0;
            d.tcp = 2'd0;
            d.tcrc = CRC_INIT;
            d.st = ST_TX;
         end
         ST_TX: begin
            if (!q.tx_valid || tx_ready_i) begin
               if (q.txi < q.nrs) begin
                  d.tx_valid = 1'b1;
                  d.tx_data = q.rs[q.txi[5:0]];
                  d.tcrc = crc_step(q.tcrc, q.rs[q.txi[5:0]]);
                  d.txi = q.txi + 8'd1;
               end else if (q.tcp == 2'd0) begin
                  d.tx_valid = 1'b1;
                  d.tx_data = q.tcrc[7:0]; // see R19
                  d.tcp = 2'd1;
               end else if (q.tcp == 2'd1) begin
                  d.tx_valid = 1'b1;
                  d.tx_data = q.tcrc[15:8];
                  d.tx_last = 1'b1;
                  d.tcp = 2'd2;
               end else begin
                  d.st = ST_IDLE;
               end
            end else begin
               d.tx_valid = q.tx_valid;
               d.tx_last = q.tx_last;
            end
         end
         ST_IDLE: d.st = ST_RX;
         default: d.st = ST_RX;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q <= '0;
         q.crc <= CRC_INIT;
         q.busy_cnt <= 32'(BUSY_CYCLES);
         q.busy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign tx_valid_o = q.tx_valid;
   assign tx_data_o = q.tx_data;
   assign tx_last_o = q.tx_last;
   assign status_bits_o = q.bits;
   assign adv_hi_temp_o = q.adv;
   assign busy_o = q.busy;

   chk_busy_exc: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (q.st == ST_EXEC && q.busy) |=> q.rs[2] == EX_BUSY && q.nrs == 8'd3)
      else $error("busy request not refused"); // see R11
   chk_drop_bad: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (q.st == ST_RX && rx_eof_i && q.bad) |=> q.st == ST_RX)
      else $error("corrupt frame acted on"); // see R14
   chk_crc_last: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (tx_valid_o && tx_last_o && tx_ready_i) |=> !tx_valid_o)
      else $error("bytes after check field"); // see R19
   chk_tx_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx byte dropped"); // see R3
   chk_bad_func: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (q.st == ST_EXEC && !q.busy && q.fr[1] == 8'h07)
      |=> q.rs[2] == EX_FUNC && q.rs[1] == 8'h87)
      else $error("illegal function not refused"); // see R11
   chk_wr_f32: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (q.st == ST_EXEC && !q.busy && q.fr[1] == FN_WR_F32
       && {q.fr[2], q.fr[3]} == F32_ADV_HI_TEMP && {q.fr[4], q.fr[5]} == 16'd1)
      |=> q.adv == {q.fr[6], q.fr[7], q.fr[8], q.fr[9]}
          && q.nrs == 8'd4)
      else $error("float write not stored"); // see R7
   chk_rsv_wr: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (q.st == ST_EXEC && q.fr[1] == FN_WR_F32
       && {q.fr[2], q.fr[3]} == F32_RSV_LO) |=> $stable(q.adv))
      else $error("reserved write altered state"); // see R5
   chk_sentinel: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (q.st == ST_EXEC && !q.busy && offline_i && $stable(max_int_i)
       && q.fr[1] == FN_RD_HOLD && {q.fr[2], q.fr[3]} == INT_LEVEL
       && {q.fr[4], q.fr[5]} inside {[16'd1:16'd16]})
      |=> {q.rs[3], q.rs[4]} == max_int_i + 16'h0001)
      else $error("sentinel not returned"); // see R17
endmodule : mbs_slave

// [tb/mbs_host_model.sv]
// Host model: sends request frames and collects the slave's replies
`timescale 1ns/10ps
module mbs_host_model (
   // Clock
   input wire logic clk_i,
   // Request stream towards the slave
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic rx_parity_err_o,
   output logic rx_eof_o,
   // Reply stream from the slave
   output logic tx_ready_o,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_last_i
);
   import mbs_pkg::*;
   bit slow;
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h5a;
      rx_parity_err_o = 1'b0;
      rx_eof_o = 1'b0;
      tx_ready_o = 1'b1;
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
         end
      end
      return c;
   endfunction : crc16
   // Frame out with check field, then gather the reply until its last byte
   task automatic xfer(input logic [7:0] req[$], input bit bad_crc,
         input bit bad_par, output logic [7:0] rsp[$], output bit crc_ok);
      logic [15:0] c;
      int idle;
      bit done;
      c = crc16(req) ^ {15'h0000, bad_crc};
      req.push_back(c[7:0]);
      req.push_back(c[15:8]);
      rsp = {};
      foreach (req[i]) begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o <= req[i];
         rx_parity_err_o <= bad_par && (i == 1);
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~req[req.size()-1];
      rx_parity_err_o <= 1'b0;
      rx_eof_o <= 1'b1;
      @(posedge clk_i);
      rx_eof_o <= 1'b0;
      idle = 0;
      done = 1'b0;
      while (!done && idle < 60) begin
         @(posedge clk_i);
         if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
            rsp.push_back(tx_data_i);
            done = (tx_last_i === 1'b1);
            idle = 0;
         end else begin
            idle++;
         end
         tx_ready_o <= (slow && !done) ? ~tx_ready_o : 1'b1;
      end
      repeat (3) @(posedge clk_i);
      crc_ok = 1'b0;
      if (rsp.size() >= 2) begin
         c = {rsp[rsp.size()-1], rsp[rsp.size()-2]};
         rsp = rsp[0:$-2];
         crc_ok = (crc16(rsp) == c);
      end
   endtask : xfer
endmodule : mbs_host_model

// [tb/modbus_float_status_slave_bench.sv]
// Testbench: request interpreter driven through a host model
`timescale 1ns/10ps
module modbus_float_status_slave_bench;
   import mbs_pkg::*;
   typedef logic [7:0] bq_t[$];
   localparam int BUSY_N = 300;
   localparam logic [7:0] A = 8'h11;
   logic clk, arst_n, rx_valid, rx_parity_err, rx_eof, tx_ready;
   logic tx_valid, tx_last, busy, level_bad, temp_bad;
   logic [7:0] rx_data, tx_data;
   logic [15:0] max_int, level_int, temp_int;
   logic [31:0] status_bits, adv_hi_temp, temp_float;
   logic [4:0] faults;
   int n_errors, n_compared, cycles;
   bq_t rsp;
   bit crc_ok;
   mbs_slave #(.BUSY_CYCLES(BUSY_N)) u_dut (.clk_i(clk), .arst_n_i(arst_n),
      .slave_addr_i(A), .max_int_i(max_int), .temp_float_i(temp_float),
      .level_int_i(level_int), .temp_int_i(temp_int),
      .level_bad_i(level_bad), .temp_bad_i(temp_bad),
      .offline_i(faults[0]), .strap_fault_i(faults[1]),
      .computation_absent_i(faults[2]),
      .correction_table_fault_i(faults[3]),
      .computation_fault_i(faults[4]), .rx_valid_i(rx_valid),
      .rx_data_i(rx_data), .rx_parity_err_i(rx_parity_err),
      .rx_eof_i(rx_eof), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
      .tx_data_o(tx_data), .tx_last_o(tx_last),
      .status_bits_o(status_bits), .adv_hi_temp_o(adv_hi_temp),
      .busy_o(busy));
   mbs_host_model u_host (.clk_i(clk), .rx_valid_o(rx_valid),
      .rx_data_o(rx_data), .rx_parity_err_o(rx_parity_err),
      .rx_eof_o(rx_eof), .tx_ready_o(tx_ready), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_last_i(tx_last));
   task automatic end_sim();
      if (n_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic ask(bq_t req, bq_t exp, string what);
      bit bad;
      u_host.xfer(req, 1'b0, 1'b0, rsp, crc_ok);
      n_compared++;
      bad = !crc_ok || rsp.size() != exp.size();
      foreach (exp[i]) if (!bad && rsp[i] !== exp[i]) bad = 1'b1;
      if (bad) begin
         n_errors++;
         $display("mismatch %s expected %p seen %p", what, exp, rsp);
      end
   endtask : ask
   function automatic bq_t rq(logic [7:0] fn, logic [15:0] a, logic [15:0] n);
      return '{A, fn, a[15:8], a[7:0], n[15:8], n[7:0]};
   endfunction : rq
   task automatic t_busy();
      chk_val("busy", 32'h1, {31'h0, busy});
      ask(rq(FN_RD_HOLD, 16'h0, 16'h1), '{A, 8'h83, EX_BUSY}, "busy");
      for (int i = 0; i < BUSY_N && busy !== 1'b0; i++) @(posedge clk);
      chk_val("busy end", 32'h0, {31'h0, busy});
   endtask : t_busy
   task automatic t_pair();
      logic [7:0] fn[2];
      fn = '{FN_RD_HOLD, FN_RD_INPR};
      foreach (fn[i]) begin
         ask(rq(fn[i], 16'h0066, 16'h2), '{A, fn[i], 8'h04, 8'h41, 8'h48,
            8'hf5, 8'hc3}, "pair read");
      end
      ask(rq(FN_RD_HOLD, 16'h0068, 16'h2), '{A, 8'h03, 8'h04, 8'h00, 8'h00,
         8'h00, 8'h00}, "reserved pair");
   endtask : t_pair
   task automatic t_f32();
      bq_t q;
      q = '{A, FN_WR_F32, 8'h00, 8'h0c, 8'h00, 8'h01, 8'h42, 8'hc8, 8'h0, 8'h0};
      ask(q, '{A, FN_WR_F32, 8'h00, 8'h01}, "f32 write");
      chk_val("setpoint", 32'h42c80000, adv_hi_temp);
      q = '{A, FN_WR_F32, 8'h00, 8'h02, 8'h00, 8'h01, 8'h3f, 8'h80, 8'h0, 8'h0};
      u_host.xfer(q, 1'b0, 1'b0, rsp, crc_ok);
      chk_val("reserved write", 32'h42c80000, adv_hi_temp);
      u_host.slow = 1'b1;
      ask(rq(FN_RD_F32, 16'h000b, 16'h3), '{A, FN_RD_F32, 8'h00, 8'h03, 8'h0,
         8'h0, 8'h0, 8'h0, 8'h42, 8'hc8, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0,
         8'h0}, "f32 read");
      u_host.slow = 1'b0;
      ask(rq(FN_RD_F32, 16'h0001, 16'h1), '{A, FN_RD_F32, 8'h00, 8'h01, 8'h41,
         8'h48, 8'hf5, 8'hc3}, "f32 temp");
      ask(rq(FN_RD_F32, 16'h0002, 16'h1), '{A, FN_RD_F32, 8'h00, 8'h01, 8'h0,
         8'h0, 8'h0, 8'h0}, "f32 reserved");
   endtask : t_f32
   task automatic t_f16();
      bq_t q;
      q = '{A, FN_WR_REGS, 8'h00, 8'h6e, 8'h00, 8'h02, 8'h04, 8'h41, 8'h20,
         8'h00, 8'h00};
      ask(q, rq(FN_WR_REGS, 16'h006e, 16'h2), "pair write");
      chk_val("pair setpoint", 32'h41200000, adv_hi_temp);
      ask(rq(FN_RD_HOLD, 16'h006e, 16'h2), '{A, 8'h03, 8'h04, 8'h41, 8'h20,
         8'h00, 8'h00}, "pair readback");
   endtask : t_f16
   task automatic t_bits();
      bq_t q;
      ask(rq(FN_WR_BIT, 16'h3, 16'hff00), rq(FN_WR_BIT, 16'h3, 16'hff00), "b5");
      q = '{A, FN_WR_BITS, 8'h00, 8'h06, 8'h00, 8'h02, 8'h01, 8'h01};
      ask(q, rq(FN_WR_BITS, 16'h6, 16'h2), "b15");
      chk_val("bits", 32'h48, status_bits);
      ask(rq(FN_RD_INPS, 16'h2, 16'h5), '{A, 8'h02, 8'h01, 8'h12}, "rd2");
      ask(rq(FN_RD_BITS, 16'h2, 16'h5), '{A, 8'h01, 8'h01, 8'h12}, "rd1");
      ask(rq(FN_WR_BIT, 16'h3, 16'h0), rq(FN_WR_BIT, 16'h3, 16'h0), "clr");
      ask(rq(FN_WR_BIT, 16'h3, 16'h1234), '{A, 8'h85, EX_VALUE}, "val");
      chk_val("bits after", 32'h40, status_bits);
   endtask : t_bits
   task automatic t_exc();
      ask(rq(8'h07, 16'h0, 16'h1), '{A, 8'h87, EX_FUNC}, "bad fn");
      ask(rq(FN_RD_BITS, 16'h20, 16'h1), '{A, 8'h81, EX_ADDR}, "bit adr");
      ask(rq(FN_RD_HOLD, 16'h18, 16'h1), '{A, 8'h83, EX_ADDR}, "reg adr");
   endtask : t_exc
   task automatic t_drop();
      bq_t q;
      q = rq(FN_WR_BIT, 16'h0, 16'hff00);
      for (int k = 0; k < 3; k++) begin
         q[0] = (k == 2) ? A + 8'h01 : A;
         u_host.xfer(q, k == 0, k == 1, rsp, crc_ok);
         chk_val("drop reply", 32'h0, rsp.size());
         chk_val("drop state", 32'h40, status_bits);
      end
   endtask : t_drop
   task automatic t_sent();
      @(posedge clk);
      max_int <= 16'd100;
      ask(rq(FN_RD_HOLD, 16'h0, 16'h2), '{A, 8'h03, 8'h04, 8'h00, 8'h32,
         8'h00, 8'h3c}, "scaled");
      for (int f = 0; f < 5; f++) begin
         @(posedge clk);
         faults <= 5'h01 << f;
         ask(rq(FN_RD_HOLD, 16'h0, 16'h6), '{A, 8'h03, 8'h0c, 8'h00, 8'h65,
            8'h00, 8'h65, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h00,
            8'h40}, "fault");
      end
      @(posedge clk);
      faults <= 5'h00;
      level_bad <= 1'b1;
      ask(rq(FN_RD_HOLD, 16'h0, 16'h2), '{A, 8'h03, 8'h04, 8'h00, 8'h65,
         8'h00, 8'h3c}, "bad level");
      @(posedge clk);
      max_int <= 16'hffff;
      ask(rq(FN_RD_HOLD, 16'h0, 16'h1), '{A, 8'h03, 8'h02, 8'h00, 8'h00},
         "max top");
   endtask : t_sent
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      arst_n = 1'b0;
      max_int = 16'd1000;
      temp_float = 32'h4148f5c3;
      level_int = 16'd50;
      temp_int = 16'd60;
      level_bad = 1'b0;
      temp_bad = 1'b0;
      faults = 5'h00;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_busy();
      t_pair();
      t_f32();
      t_f16();
      t_bits();
      t_exc();
      t_drop();
      t_sent();
      end_sim();
   end
endmodule : modbus_float_status_slave_bench
